/* common/ufc_pkg.sv */
/*
 * Constants, field layouts and types for the serial port frame-format
 * control block. Assumes a 32-bit AXI4-Lite bus with byte addresses.
 */
package ufc_pkg;
  // Register byte offsets
  localparam logic [11:0] UFC_OFS_DATA   = 12'h000;
  localparam logic [11:0] UFC_OFS_FLAGS  = 12'h018;
  localparam logic [11:0] UFC_OFS_DIVINT = 12'h024;
  localparam logic [11:0] UFC_OFS_LINE   = 12'h02C;
  localparam logic [11:0] UFC_OFS_CTL    = 12'h030;
  // Port control bit positions
  localparam int UFC_CTL_MODULE_EN = 0;
  localparam int UFC_CTL_CARD      = 3;
  localparam int UFC_CTL_TX_EN     = 8;
  localparam int UFC_CTL_RX_EN     = 9;
  // Flag register bit positions
  localparam int UFC_FLG_BUSY      = 3;
  localparam int UFC_FLG_RX_EMPTY  = 4;
  localparam int UFC_FLG_TX_FULL   = 5;
  localparam int UFC_FLG_RX_FULL   = 6;
  localparam int UFC_FLG_TX_EMPTY  = 7;
  // Reset values
  localparam logic [31:0] UFC_CTL_RESET  = 32'h0000_0300;
  localparam logic [7:0]  UFC_LINE_RESET = 8'h00;
  localparam logic [15:0] UFC_DIV_RESET  = 16'h0000;
  // Buffer depths: FIFO mode and character mode
  localparam logic [4:0]  UFC_FIFO_DEPTH = 5'h10;
  localparam logic [4:0]  UFC_CHAR_DEPTH = 5'h01;
  localparam logic [1:0]  UFC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  UFC_RESP_SLVERR = 2'h2;

  // Line frame control, bit 7 down to bit 0
  typedef struct packed {
    logic       stick_parity_sel;
    logic [1:0] word_length_sel;
    logic       fifo_enable;
    logic       two_stop_select;
    logic       even_parity_select;
    logic       parity_enable;
    logic       send_break;
  } ufc_line_t;

  typedef struct packed {
    logic module_enable;
    logic card_mode;
    logic transmit_enable;
    logic receive_enable;
  } ufc_ctl_t;

  // Received entry: errors above the data byte
  typedef struct packed {
    logic       parity_err;
    logic       frame_err;
    logic [7:0] data;
  } ufc_rx_t;
endpackage : ufc_pkg

/* src/ufc_top.sv */
/*
 * Frame-format and enable control of an asynchronous serial port, with
 * transmitter, receiver, buffers and an AXI4-Lite register slave.
 * Assumes serial_in_pin is already synchronous to aclk.
 */
// Implementation choice: the AXI4-Lite interface to the registers.
// Contract
// - FIFO enable set: both buffers are FIFOs
// - FIFO enable clear: one-byte holding registers
// - Two-stop select set: two stop bits sent
// - Receiver never checks a second stop bit
// - Card mode forces two stop bits
// - Two-stop select clear: one stop bit
// - Even select: even count of ones
// - Even select clear: odd parity
// - Even select ignored without parity enable
// - Parity enable inserts and checks parity
// - Parity disabled: no bit, no check
// - Break: finish character, then hold low
// - Reset clears control except both enables
// - Transfer only while module enable set
// - Disable mid-character completes that character
// - Word length code selects five to eight
// - Stick parity sends constant parity bit
// - Divisor takes effect on line register write
`timescale 1ns/1ps
module ufc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin
);
  // Parity bit for a character under the current line settings
  function automatic logic ufc_parity(input logic [7:0] d,
                                      input ufc_pkg::ufc_line_t l);
    logic [7:0] mask;
    mask = 8'hFF >> (2'd3 - l.word_length_sel);
    if (l.stick_parity_sel)
      ufc_parity = ~l.even_parity_select;
    else
      ufc_parity = (^(d & mask)) ^ ~l.even_parity_select;
  endfunction : ufc_parity

  // Byte-lane merge for partial writes
  function automatic logic [31:0] ufc_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  strb);
    for (int i = 0; i < 4; i++)
      ufc_merge[i*8 +: 8] = strb[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
  endfunction : ufc_merge

  ufc_pkg::ufc_ctl_t   ctl,        next_ctl;
  ufc_pkg::ufc_line_t  line,       next_line;
  logic [15:0]         div_int,    next_div_int;
  logic [15:0]         div_active, next_div_active;
  logic [7:0]          tx_mem [16];
  logic [7:0]          next_tx_mem [16];
  ufc_pkg::ufc_rx_t    rx_mem [16];
  ufc_pkg::ufc_rx_t    next_rx_mem [16];
  logic [3:0]          tx_rd,      next_tx_rd;
  logic [4:0]          tx_cnt,     next_tx_cnt;
  logic [3:0]          rx_rd,      next_rx_rd;
  logic [4:0]          rx_cnt,     next_rx_cnt;
  logic                aw_got,     next_aw_got;
  logic                w_got,      next_w_got;
  logic [11:0]         aw_addr,    next_aw_addr;
  logic [31:0]         w_data,     next_w_data;
  logic [3:0]          w_strb,     next_w_strb;
  logic                next_awready, next_wready, next_bvalid;
  logic                next_arready, next_rvalid;
  logic [1:0]          next_bresp, next_rresp;
  logic [31:0]         next_rdata;
  logic [4:0]          cap;
  logic [31:0]         merged;
  logic                tx_pop;
  logic                rx_push;
  ufc_pkg::ufc_rx_t    rx_entry;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP, TX_BREAK}
    ufc_tx_state_t;
  ufc_tx_state_t tx_state, next_tx_state;
  logic [15:0]         tx_timer,   next_tx_timer;
  logic [2:0]          tx_idx,     next_tx_idx;
  logic [7:0]          tx_shift,   next_tx_shift;
  logic                tx_par,     next_tx_par;
  logic                tx_more,    next_tx_more;
  logic                next_serial_out;
  logic [2:0]          last_idx;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP}
    ufc_rx_state_t;
  ufc_rx_state_t rx_state, next_rx_state;
  logic [15:0]         rx_timer,   next_rx_timer;
  logic [2:0]          rx_idx,     next_rx_idx;
  logic [7:0]          rx_shift,   next_rx_shift;
  logic                rx_perr,    next_rx_perr;
  logic [7:0]          rx_data;

  // Data bits per frame minus one: 4 + code
  assign last_idx = {1'b0, line.word_length_sel} + 3'd4;
  // Receive shift fills from the top; align short words down
  assign rx_data  = rx_shift >> (2'd3 - line.word_length_sel);

  // Bus slave, registers and both buffers
  always_comb begin
    next_ctl        = ctl;
    next_line       = line;
    next_div_int    = div_int;
    next_div_active = div_active;
    next_tx_mem     = tx_mem;
    next_rx_mem     = rx_mem;
    next_tx_rd      = tx_rd;
    next_tx_cnt     = tx_cnt;
    next_rx_rd      = rx_rd;
    next_rx_cnt     = rx_cnt;
    next_aw_got     = aw_got;
    next_w_got      = w_got;
    next_aw_addr    = aw_addr;
    next_w_data     = w_data;
    next_w_strb     = w_strb;
    next_bvalid     = s_axi_bvalid;
    next_bresp      = s_axi_bresp;
    next_rvalid     = s_axi_rvalid;
    next_rresp      = s_axi_rresp;
    next_rdata      = s_axi_rdata;
    merged          = 32'h0000_0000;
    // Character mode shrinks each buffer to one byte
    cap = line.fifo_enable ? ufc_pkg::UFC_FIFO_DEPTH
                           : ufc_pkg::UFC_CHAR_DEPTH;
    // Transmitter drain, receiver fill; a full buffer drops the entry
    if (tx_pop) begin
      next_tx_rd  = tx_rd + 4'h1;
      next_tx_cnt = tx_cnt - 5'h01;
    end
    if (rx_push && rx_cnt < cap) begin
      next_rx_mem[4'(rx_rd + rx_cnt[3:0])] = rx_entry;
      next_rx_cnt = next_rx_cnt + 5'h01;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got  = 1'b1;
      next_aw_addr = s_axi_awaddr[11:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got  = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    // Write happens once both address and data are held
    if (aw_got && w_got && !s_axi_bvalid) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = ufc_pkg::UFC_RESP_OKAY;
      case (aw_addr)
        ufc_pkg::UFC_OFS_DATA: begin
          merged = ufc_merge(32'h0000_0000, w_data, w_strb);
          if (next_tx_cnt < cap) begin
            next_tx_mem[4'(tx_rd + tx_cnt[3:0])] = merged[7:0];
            next_tx_cnt = next_tx_cnt + 5'h01;
          end
        end
        ufc_pkg::UFC_OFS_DIVINT: begin
          merged       = ufc_merge({16'h0000, div_int}, w_data, w_strb);
          next_div_int = merged[15:0];
        end
        ufc_pkg::UFC_OFS_LINE: begin
          merged    = ufc_merge({24'h00_0000, line}, w_data, w_strb);
          next_line = merged[7:0];
          next_div_active = div_int;
          // Clearing FIFO enable empties the transmit buffer
          if (line.fifo_enable && !next_line.fifo_enable) begin
            next_tx_cnt = 5'h00;
          end
        end
        ufc_pkg::UFC_OFS_CTL: begin
          merged = ufc_merge({22'h00_0000, ctl.receive_enable,
                              ctl.transmit_enable, 4'h0, ctl.card_mode,
                              2'h0, ctl.module_enable}, w_data, w_strb);
          next_ctl.module_enable   = merged[ufc_pkg::UFC_CTL_MODULE_EN];
          next_ctl.card_mode       = merged[ufc_pkg::UFC_CTL_CARD];
          next_ctl.transmit_enable = merged[ufc_pkg::UFC_CTL_TX_EN];
          next_ctl.receive_enable  = merged[ufc_pkg::UFC_CTL_RX_EN];
        end
        ufc_pkg::UFC_OFS_FLAGS: ;
        default: next_bresp = ufc_pkg::UFC_RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    // Read answer; reading data pops the receive buffer
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = ufc_pkg::UFC_RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      case (s_axi_araddr[11:0])
        ufc_pkg::UFC_OFS_DATA: begin
          if (rx_cnt != 5'h00) begin
            next_rdata[9:0] = rx_mem[rx_rd];
            next_rx_rd      = rx_rd + 4'h1;
            next_rx_cnt     = next_rx_cnt - 5'h01;
          end
        end
        ufc_pkg::UFC_OFS_FLAGS: begin
          next_rdata[ufc_pkg::UFC_FLG_BUSY]     = tx_state != TX_IDLE;
          next_rdata[ufc_pkg::UFC_FLG_RX_EMPTY] = rx_cnt == 5'h00;
          next_rdata[ufc_pkg::UFC_FLG_TX_FULL]  = tx_cnt >= cap;
          next_rdata[ufc_pkg::UFC_FLG_RX_FULL]  = rx_cnt >= cap;
          next_rdata[ufc_pkg::UFC_FLG_TX_EMPTY] = tx_cnt == 5'h00;
        end
        ufc_pkg::UFC_OFS_DIVINT: next_rdata[15:0] = div_int;
        ufc_pkg::UFC_OFS_LINE:   next_rdata[7:0]  = line;
        ufc_pkg::UFC_OFS_CTL: begin
          next_rdata[ufc_pkg::UFC_CTL_MODULE_EN] = ctl.module_enable;
          next_rdata[ufc_pkg::UFC_CTL_CARD]      = ctl.card_mode;
          next_rdata[ufc_pkg::UFC_CTL_TX_EN]     = ctl.transmit_enable;
          next_rdata[ufc_pkg::UFC_CTL_RX_EN]     = ctl.receive_enable;
        end
        default: next_rresp = ufc_pkg::UFC_RESP_SLVERR;
      endcase
    end
    next_awready = !next_aw_got;
    next_wready  = !next_w_got;
    next_arready = !next_rvalid;
  end

  // Register group; control resets with both enables set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl.module_enable   <= ufc_pkg::UFC_CTL_RESET[ufc_pkg::UFC_CTL_MODULE_EN];
      ctl.card_mode       <= ufc_pkg::UFC_CTL_RESET[ufc_pkg::UFC_CTL_CARD];
      ctl.transmit_enable <= ufc_pkg::UFC_CTL_RESET[ufc_pkg::UFC_CTL_TX_EN];
      ctl.receive_enable  <= ufc_pkg::UFC_CTL_RESET[ufc_pkg::UFC_CTL_RX_EN];
      line          <= ufc_pkg::UFC_LINE_RESET;
      div_int       <= ufc_pkg::UFC_DIV_RESET;
      div_active    <= ufc_pkg::UFC_DIV_RESET;
      tx_rd         <= 4'h0;
      tx_cnt        <= 5'h00;
      rx_rd         <= 4'h0;
      rx_cnt        <= 5'h00;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ufc_pkg::UFC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= ufc_pkg::UFC_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      ctl           <= next_ctl;
      line          <= next_line;
      div_int       <= next_div_int;
      div_active    <= next_div_active;
      tx_rd         <= next_tx_rd;
      tx_cnt        <= next_tx_cnt;
      rx_rd         <= next_rx_rd;
      rx_cnt        <= next_rx_cnt;
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
    end
    // Buffer storage needs no reset: counts guard every read
    tx_mem <= next_tx_mem;
    rx_mem <= next_rx_mem;
  end

  // Transmitter; each bit lasts div_active + 1 clocks
  always_comb begin
    next_tx_state   = tx_state;
    next_tx_timer   = tx_timer;
    next_tx_idx     = tx_idx;
    next_tx_shift   = tx_shift;
    next_tx_par     = tx_par;
    next_tx_more    = tx_more;
    next_serial_out = serial_out_pin;
    tx_pop          = 1'b0;
    if (tx_state != TX_IDLE && tx_state != TX_BREAK)
      next_tx_timer = (tx_timer == 16'h0000) ? div_active
                                             : tx_timer - 16'h0001;
    case (tx_state)
      TX_IDLE: begin
        next_serial_out = 1'b1;
        // Break only from idle, so a character under way completes
        if (line.send_break) begin
          next_tx_state   = TX_BREAK;
          next_serial_out = 1'b0;
        end else if (ctl.module_enable && ctl.transmit_enable &&
                     tx_cnt != 5'h00) begin
          tx_pop          = 1'b1;
          next_tx_shift   = tx_mem[tx_rd];
          next_tx_par     = ufc_parity(tx_mem[tx_rd], line);
          next_tx_timer   = div_active;
          next_tx_state   = TX_START;
          next_serial_out = 1'b0;
        end
      end
      TX_START: if (tx_timer == 16'h0000) begin
        next_tx_state   = TX_DATA;
        next_tx_idx     = 3'h0;
        next_serial_out = tx_shift[0];
      end
      TX_DATA: if (tx_timer == 16'h0000) begin
        if (tx_idx == last_idx) begin
          next_tx_more = line.two_stop_select || ctl.card_mode;
          if (line.parity_enable) begin
            next_tx_state   = TX_PARITY;
            next_serial_out = tx_par;
          end else begin
            next_tx_state   = TX_STOP;
            next_serial_out = 1'b1;
          end
        end else begin
          next_tx_idx     = tx_idx + 3'h1;
          next_tx_shift   = tx_shift >> 1;
          next_serial_out = tx_shift[1];
        end
      end
      TX_PARITY: if (tx_timer == 16'h0000) begin
        next_tx_state   = TX_STOP;
        next_serial_out = 1'b1;
      end
      // Mid-character disable is ignored until the last stop bit
      TX_STOP: if (tx_timer == 16'h0000) begin
        if (tx_more)
          next_tx_more  = 1'b0;
        else
          next_tx_state = TX_IDLE;
      end
      TX_BREAK: begin
        next_serial_out = line.send_break ? 1'b0 : 1'b1;
        if (!line.send_break)
          next_tx_state = TX_IDLE;
      end
      default: next_tx_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state       <= TX_IDLE;
      tx_timer       <= 16'h0000;
      tx_idx         <= 3'h0;
      tx_shift       <= 8'h00;
      tx_par         <= 1'b0;
      tx_more        <= 1'b0;
      serial_out_pin <= 1'b1;
    end else begin
      tx_state       <= next_tx_state;
      tx_timer       <= next_tx_timer;
      tx_idx         <= next_tx_idx;
      tx_shift       <= next_tx_shift;
      tx_par         <= next_tx_par;
      tx_more        <= next_tx_more;
      serial_out_pin <= next_serial_out;
    end
  end

  // Receiver; samples mid-bit, half a period after the start edge
  always_comb begin
    next_rx_state = rx_state;
    next_rx_timer = rx_timer;
    next_rx_idx   = rx_idx;
    next_rx_shift = rx_shift;
    next_rx_perr  = rx_perr;
    rx_push       = 1'b0;
    rx_entry      = {rx_perr, ~serial_in_pin, rx_data};
    if (rx_state != RX_IDLE)
      next_rx_timer = (rx_timer == 16'h0000) ? div_active
                                             : rx_timer - 16'h0001;
    case (rx_state)
      RX_IDLE: if (ctl.module_enable && ctl.receive_enable &&
                   !serial_in_pin) begin
        next_rx_state = RX_START;
        next_rx_timer = div_active >> 1;
        next_rx_perr  = 1'b0;
      end
      // A start bit gone high at mid-bit was a glitch
      RX_START: if (rx_timer == 16'h0000) begin
        next_rx_state = serial_in_pin ? RX_IDLE : RX_DATA;
        next_rx_idx   = 3'h0;
      end
      RX_DATA: if (rx_timer == 16'h0000) begin
        next_rx_shift = {serial_in_pin, rx_shift[7:1]};
        next_rx_idx   = rx_idx + 3'h1;
        if (rx_idx == last_idx)
          next_rx_state = line.parity_enable ? RX_PARITY
                                             : RX_STOP;
      end
      RX_PARITY: if (rx_timer == 16'h0000) begin
        next_rx_perr  = serial_in_pin != ufc_parity(rx_data, line);
        next_rx_state = RX_STOP;
      end
      // Only the first stop bit is checked; a second one reads as idle
      RX_STOP: if (rx_timer == 16'h0000) begin
        rx_push       = 1'b1;
        next_rx_state = RX_IDLE;
      end
      default: next_rx_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state <= RX_IDLE;
      rx_timer <= 16'h0000;
      rx_idx   <= 3'h0;
      rx_shift <= 8'h00;
      rx_perr  <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_timer <= next_rx_timer;
      rx_idx   <= next_rx_idx;
      rx_shift <= next_rx_shift;
      rx_perr  <= next_rx_perr;
    end
  end
endmodule : ufc_top

/* test/ufc_chk.sv */
/*
 * Bus and line checker for ufc_top, bound into the top module.
 * Assumes the bench programs a divisor of 3, so a bit lasts four clocks.
 */
`timescale 1ns/1ps
module ufc_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        serial_out_pin
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Line idle and no answer pending straight after reset
  property p_rst_idle;
    $rose(aresetn) |-> serial_out_pin && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("busy after reset");
  // Address slot closes once taken
  property p_aw_busy;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("awready stayed high");
  // Answers stand until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  // Read data follows the address by one cycle
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  // Unmapped offsets refused with an error response
  property p_bad_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:0] == 12'h040
      |=> s_axi_rresp == 2'h2;
  endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("unmapped read okay");
  property p_bad_wr;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr[11:0] == 12'h040
      |-> ##[1:8] s_axi_bvalid && s_axi_bresp == 2'h2;
  endproperty
  a_bad_wr: assert property (p_bad_wr) else $error("unmapped write okay");
  // A start bit or break lasts at least one whole bit
  property p_start_len;
    $fell(serial_out_pin) |-> !serial_out_pin [*4];
  endproperty
  a_start_len: assert property (p_start_len) else $error("short low bit");
endmodule : ufc_chk

bind ufc_top ufc_chk ufc_chk_inst (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .serial_out_pin);

/* test/ufc_remote.sv */
/*
 * Remote serial device: drives the receive line, captures the transmit
 * line. Assumes callers return just after a rising clock edge.
 */
`timescale 1ns/1ps
module ufc_remote #(
  parameter int BIT_CLKS = 4
) (
  input  wire logic aclk,
  input  wire logic serial_out_pin,
  output logic      serial_in_pin
);
  initial serial_in_pin = 1'b1;
  // Bits go out LSB first, line back to idle high afterwards
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      serial_in_pin <= f[i];
      repeat (BIT_CLKS) @(posedge aclk);
    end
    serial_in_pin <= 1'b1;
  endtask : send
  // Mid-bit sampling keeps clear of edges on either side
  task automatic capture(output logic [23:0] f);
    do @(posedge aclk); while (serial_out_pin !== 1'b0);
    repeat (BIT_CLKS / 2) @(posedge aclk);
    for (int i = 0; i < 24; i++) begin
      f[i] = serial_out_pin;
      repeat (BIT_CLKS) @(posedge aclk);
    end
  endtask : capture
endmodule : ufc_remote

/* test/tb_uart_frame_format_control.sv */
/*
 * Bench for ufc_top: AXI4-Lite master tasks, random frame formats and a
 * remote device on the serial pins. Assumes the checker is bound.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_uart_frame_format_control;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_in_pin;
  logic        serial_out_pin;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          n_errors = 0, n_compared = 0, cycles = 0;

  ufc_top ufc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_in_pin,
    .serial_out_pin);
  ufc_remote ufc_remote_inst (.aclk, .serial_out_pin, .serial_in_pin);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Ceiling far above the few thousand cycles the run needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  // Ready raised late on purpose, so answers must stand
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= {20'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= {20'h0, a};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Line bits LSB first, idle ones above the frame
  function automatic logic [11:0] frame(ufc_pkg::ufc_line_t l,
                                        logic [7:0] d, logic flip);
    logic [11:0] f;
    int          nd;
    nd = 5 + l.word_length_sel;
    f = 12'hfff;
    f[0] = 1'b0;
    for (int i = 0; i < nd; i++) f[1 + i] = d[i];
    if (l.parity_enable) f[1 + nd] = flip ^ ~l.even_parity_select ^
      (~l.stick_parity_sel & ^(d & (8'hff >> (8 - nd))));
    return f;
  endfunction : frame
  function automatic int flen(ufc_pkg::ufc_line_t l, logic card);
    return 7 + l.word_length_sel + l.parity_enable +
      (l.two_stop_select | card);
  endfunction : flen

  initial begin
    ufc_pkg::ufc_line_t l;
    logic [7:0]         d0, d1;
    logic [23:0]        got, e;
    logic               card, flip, hi;
    int                 n;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rready} = 97'h0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    n = $urandom(47343);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ufc_pkg::UFC_OFS_CTL);
    `CHK(rd_data, ufc_pkg::UFC_CTL_RESET)
    rd(ufc_pkg::UFC_OFS_LINE);
    `CHK(rd_data[7:0], ufc_pkg::UFC_LINE_RESET)
    rd(12'h040);
    `CHK(resp, ufc_pkg::UFC_RESP_SLVERR)
    wr(12'h040, 32'h0);
    `CHK(resp, ufc_pkg::UFC_RESP_SLVERR)
    wr(ufc_pkg::UFC_OFS_DIVINT, 32'h3);
    $display("test reset done");
    // Random formats, both buffer modes forced first
    for (int t = 0; t < 12; t++) begin
      l = ufc_pkg::ufc_line_t'(8'($urandom));
      l.send_break = 1'b0;
      if (t < 2) l.fifo_enable = t[0];
      card = 1'($urandom);
      flip = 1'($urandom);
      {d0, d1} = 16'($urandom);
      wr(ufc_pkg::UFC_OFS_CTL, 32'h300);
      wr(ufc_pkg::UFC_OFS_LINE, {24'h0, l});
      wr(ufc_pkg::UFC_OFS_DATA, {24'h0, d0});
      wr(ufc_pkg::UFC_OFS_DATA, {24'h0, d1});
      hi = 1'b1;
      repeat (40) begin
        @(posedge aclk);
        hi &= serial_out_pin;
      end
      `CHK(hi, 1'b1)
      n = flen(l, card);
      e = {12'hfff, frame(l, d0, 1'b0)};
      if (l.fifo_enable)
        e &= ({12'hfff, frame(l, d1, 1'b0)} << n) | ((24'h1 << n) - 24'h1);
      fork
        ufc_remote_inst.capture(got);
        wr(ufc_pkg::UFC_OFS_CTL, 32'h301 | {28'h0, card, 3'h0});
      join
      `CHK(got, e)
      ufc_remote_inst.send(frame(l, d0, flip), n);
      repeat (4) @(posedge aclk);
      rd(ufc_pkg::UFC_OFS_DATA);
      e = {flip & l.parity_enable, 1'b0,
        d0 & (8'hff >> (3 - l.word_length_sel))};
      `CHK(rd_data[9:0], e[9:0])
      $display("test frame %0d done", t);
    end
    // Break held 96 clocks, two of the longest (12-bit) character periods
    l.send_break = 1'b1;
    wr(ufc_pkg::UFC_OFS_LINE, {24'h0, l});
    repeat (4) @(posedge aclk);
    hi = 1'b0;
    repeat (96) begin
      @(posedge aclk);
      hi |= serial_out_pin;
    end
    `CHK(hi, 1'b0)
    l.send_break = 1'b0;
    wr(ufc_pkg::UFC_OFS_LINE, {24'h0, l});
    repeat (4) @(posedge aclk);
    `CHK(serial_out_pin, 1'b1)
    $display("test break done");
    print_verdict();
  end
endmodule : tb_uart_frame_format_control
